//--- hdl/audio_link_cfg.svh
`ifndef AUDIO_LINK_CFG_SVH
`define AUDIO_LINK_CFG_SVH

// ----------------------------------------
// Frame layout
// ----------------------------------------
`define ALK_FRAME_BITS 28
`define ALK_SMP_W 24
`define ALK_START_BIT 24
`define ALK_CTL_BIT 25
`define ALK_LR_BIT 26
`define ALK_PAR_BIT 27
`define ALK_LFSR_SEED 7'h5B

// ----------------------------------------
// Register offsets and reset values
// ----------------------------------------
`define ALK_DES_ERR_LO 8'h1A
`define ALK_DES_ERR_HI 8'h1B
`define ALK_DES_CTRL 8'h20
`define ALK_DES_STAT 8'h21
`define ALK_DES_CTRL_RST 5'h00
`define ALK_SER_CTRL 8'h00
`define ALK_SER_STAT 8'h01
`define ALK_SER_CTRL_RST 3'h0

// ----------------------------------------
// Timing
// ----------------------------------------
`define ALK_CLK_MHZ 100
`define ALK_LINK_HALF 4
`define ALK_BCK_HALF 4
`define ALK_LOCK_FRAMES 2
`define ALK_LINK_TO_CYC 64
`define ALK_PASS_LOW_NS 1000
`define ALK_PASS_LOW_CYC ((`ALK_PASS_LOW_NS * `ALK_CLK_MHZ + 999) / 1000)

`endif

//--- hdl/audio_link_pkg.sv
package audio_link_pkg;

	typedef enum logic [1:0] {FMT_STD, FMT_LJ, FMT_RJ, FMT_TDM} fmt_t;

	typedef enum logic [1:0] {LK_HUNT, LK_CHECK, LK_LOCKED} lock_st_t;

	function automatic logic [6:0] lfsr_step(input logic [6:0] s);
		lfsr_step = {s[5:0], s[6] ^ s[5]};
	endfunction

endpackage

//--- hdl/audio_link_if.sv
`timescale 1ns/1ps

interface audio_link_if;
	logic link_clk;
	logic link_data;
	logic link_sync;

	modport ser_end (output link_clk, output link_data, output link_sync);
	modport des_end (input link_clk, input link_data, input link_sync);
endinterface

//--- hdl/audio_link_ser.sv
`timescale 1ns/1ps
`include "audio_link_cfg.svh"

module audio_link_ser (
	// Clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// Register port
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_we_i,
	input wire logic reg_re_i,
	output logic [7:0] reg_rdata_o,
	// Sample input
	input wire logic [23:0] smp_data_i,
	input wire logic smp_start_i,
	input wire logic smp_lr_i,
	input wire logic smp_valid_i,
	output logic smp_ready_o,
	// Link
	audio_link_if.ser_end link
);
	logic [2:0] ctrl_q;
	logic [2:0] div_q;
	logic lclk_q;
	logic [4:0] bit_q;
	logic [6:0] lfsr_q;
	logic [25:0] pend_q;
	logic pend_v_q;
	logic [27:0] word_q;
	logic dat_q;
	logic syn_q;
	logic fall;
	logic [26:0] nxt;
	localparam logic [6:0] seed_c = `ALK_LFSR_SEED;

	assign link.link_clk = lclk_q;
	assign link.link_data = dat_q;
	assign link.link_sync = syn_q;
	assign smp_ready_o = ~pend_v_q;
	assign fall = (div_q == 3'(`ALK_LINK_HALF - 1)) && lclk_q;
	// Frame body without parity: lr, ctl, start, sample
	assign nxt = pend_v_q ? {pend_q[25], ctrl_q[2], pend_q[24:0]}
		: {word_q[26], ctrl_q[2], word_q[24:0]};

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			ctrl_q <= `ALK_SER_CTRL_RST;
		end else if (reg_we_i && reg_addr_i == `ALK_SER_CTRL) begin
			ctrl_q <= reg_wdata_i[2:0];
		end else if (fall && bit_q == 5'h00 && ctrl_q[0]) begin
			// Forced error lasts one frame only
			ctrl_q[1] <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			reg_rdata_o <= 8'h00;
		end else if (reg_re_i && reg_addr_i == `ALK_SER_CTRL) begin
			reg_rdata_o <= {5'h00, ctrl_q};
		end else if (reg_re_i && reg_addr_i == `ALK_SER_STAT) begin
			reg_rdata_o <= {6'h00, pend_v_q, ctrl_q[0]};
		end else begin
			reg_rdata_o <= 8'h00;
		end
	end

	// ----------------------------------------
	// Link clock divider
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (sys_rst_i || !ctrl_q[0]) begin
			div_q <= 3'h0;
			lclk_q <= 1'b0;
		end else if (div_q == 3'(`ALK_LINK_HALF - 1)) begin
			div_q <= 3'h0;
			lclk_q <= ~lclk_q;
		end else begin
			div_q <= div_q + 3'h1;
		end
	end

	// ----------------------------------------
	// Sample holding
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			pend_v_q <= 1'b0;
			pend_q <= 26'h0000000;
		end else if (smp_valid_i && !pend_v_q) begin
			pend_v_q <= 1'b1;
			pend_q <= {smp_lr_i, smp_start_i, smp_data_i};
		end else if (fall && bit_q == 5'h00) begin
			pend_v_q <= 1'b0;
		end
	end

	// ----------------------------------------
	// Frame shifter
	// ----------------------------------------
	// data changes on falling edge
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			bit_q <= 5'h00;
			lfsr_q <= `ALK_LFSR_SEED;
			word_q <= 28'h0000000;
			dat_q <= 1'b0;
			syn_q <= 1'b0;
		end else if (fall) begin
			bit_q <= (bit_q == 5'(`ALK_FRAME_BITS - 1)) ? 5'h00 : bit_q + 5'h01;
			syn_q <= (bit_q == 5'h00);
			if (bit_q == 5'h00) begin
				// parity closes 28-bit frame
				// Without a fresh sample the last frame repeats
				word_q <= {(^nxt) ^ ctrl_q[1], nxt};
				lfsr_q <= audio_link_pkg::lfsr_step(seed_c);
				dat_q <= nxt[0] ^ seed_c[0];
			end else begin
				lfsr_q <= audio_link_pkg::lfsr_step(lfsr_q);
				dat_q <= word_q[bit_q] ^ lfsr_q[0];
			end
		end
	end

endmodule

//--- hdl/audio_link_des.sv
`timescale 1ns/1ps
`include "audio_link_cfg.svh"

// Notes on behaviour
// - each frame carries 28 bits
// - frame payload scrambled, receiver descrambles it
// - bit clock covers rate times bits times channels
// - stereo word clock low left, high right
// - standard stereo: word clock leads MSB one bit
// - samples two's complement, MSB first
// - receiver truncates long, zero-fills short words
// - data changes falling edge, sampled rising
// - left-justified MSB aligned with word clock edge
// - right-justified LSB just before word clock edge
// - TDM carries 2, 4 or 8 channels
// - TDM frame 256 bit clocks, 8x32, 4x64 or 2x128
// - TDM word clock pulse one bit or slot
// - one parity bit per frame
// - parity errors counted at 0x1A and 0x1B
// - loss of lock clears both counters
// - pass pin pulses low on parity error
// - audio system clock between 10 and 50 MHz

module audio_link_des (
	// Clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// Link
	audio_link_if.des_end link,
	// Register port
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_we_i,
	input wire logic reg_re_i,
	output logic [7:0] reg_rdata_o,
	// Audio outputs
	output logic sck_o,
	output logic bck_o,
	output logic lrck_o,
	output logic dout_o,
	// Status pins
	output logic lock_o,
	output logic pass_o
);
	logic [1:0] lclk_s_q;
	logic [1:0] ldat_s_q;
	logic [1:0] lsyn_s_q;
	logic lclk_prev_q;
	logic rise;
	logic rx_bit;
	logic [4:0] rbit_q;
	logic [6:0] lfsr_q;
	logic [27:0] frame_q;
	logic done_q;
	logic bad;
	logic [6:0] idle_q;
	logic [1:0] good_q;
	audio_link_pkg::lock_st_t lk_q;
	logic [15:0] err_q;
	logic [7:0] pass_cnt_q;
	logic ctl_q;
	logic [2:0] ch_q;
	logic [2:0] ch_nx;
	logic [23:0] mem_q [0:7];
	logic [4:0] ctrl_q;
	audio_link_pkg::fmt_t fmt;
	logic [2:0] div_q;
	logic fall;
	logic [7:0] cnt_q;
	logic [7:0] nc;
	logic [7:0] last;
	logic [2:0] sh;
	logic [2:0] slot;
	logic [7:0] pos;
	logic [23:0] cur_q;
	logic [23:0] word;
	int k;
	int off;
	localparam logic [6:0] seed_c = `ALK_LFSR_SEED;

	assign fmt = audio_link_pkg::fmt_t'(ctrl_q[1:0]);

	// ----------------------------------------
	// Link input synchronisers
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			lclk_s_q <= 2'h0;
			ldat_s_q <= 2'h0;
			lsyn_s_q <= 2'h0;
			lclk_prev_q <= 1'b0;
		end else begin
			lclk_s_q <= {lclk_s_q[0], link.link_clk};
			ldat_s_q <= {ldat_s_q[0], link.link_data};
			lsyn_s_q <= {lsyn_s_q[0], link.link_sync};
			lclk_prev_q <= lclk_s_q[1];
		end
	end

	assign rise = lclk_s_q[1] && !lclk_prev_q;
	assign rx_bit = ldat_s_q[1] ^ (lsyn_s_q[1] ? seed_c[0] : lfsr_q[0]);
	assign bad = (rise && (lsyn_s_q[1] != (rbit_q == 5'(`ALK_FRAME_BITS))))
		|| (idle_q == 7'(`ALK_LINK_TO_CYC));

	// ----------------------------------------
	// Frame receiver
	// ----------------------------------------
	// gather 28 bits per frame
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			rbit_q <= 5'h00;
			lfsr_q <= `ALK_LFSR_SEED;
			frame_q <= 28'h0000000;
			done_q <= 1'b0;
		end else begin
			done_q <= rise && !lsyn_s_q[1] && rbit_q == 5'(`ALK_FRAME_BITS - 1);
			if (rise && lsyn_s_q[1]) begin
				frame_q[0] <= rx_bit;
				rbit_q <= 5'h01;
				lfsr_q <= audio_link_pkg::lfsr_step(`ALK_LFSR_SEED);
			end else if (rise && rbit_q < 5'(`ALK_FRAME_BITS)) begin
				frame_q[rbit_q] <= rx_bit;
				rbit_q <= rbit_q + 5'h01;
				lfsr_q <= audio_link_pkg::lfsr_step(lfsr_q);
			end
		end
	end

	// ----------------------------------------
	// Lock tracking
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (sys_rst_i || rise) begin
			idle_q <= 7'h00;
		end else if (idle_q != 7'(`ALK_LINK_TO_CYC)) begin
			idle_q <= idle_q + 7'h01;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			lk_q <= audio_link_pkg::LK_HUNT;
			good_q <= 2'h0;
		end else begin
			case (lk_q)
				audio_link_pkg::LK_HUNT: begin
					good_q <= 2'h0;
					if (rise && lsyn_s_q[1]) begin
						lk_q <= audio_link_pkg::LK_CHECK;
					end
				end
				audio_link_pkg::LK_CHECK: begin
					if (bad) begin
						lk_q <= audio_link_pkg::LK_HUNT;
					end else if (rise && lsyn_s_q[1]) begin
						good_q <= good_q + 2'h1;
						if (good_q == 2'(`ALK_LOCK_FRAMES - 1)) begin
							lk_q <= audio_link_pkg::LK_LOCKED;
						end
					end
				end
				audio_link_pkg::LK_LOCKED: begin
					if (bad) begin
						lk_q <= audio_link_pkg::LK_HUNT;
					end
				end
				default: begin
					lk_q <= audio_link_pkg::LK_HUNT;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			lock_o <= 1'b0;
		end else begin
			lock_o <= (lk_q == audio_link_pkg::LK_LOCKED);
		end
	end

	// ----------------------------------------
	// Parity check and error counting
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (sys_rst_i || lk_q != audio_link_pkg::LK_LOCKED) begin
			err_q <= 16'h0000;
		end else if (done_q && ^frame_q && err_q != 16'hFFFF) begin
			err_q <= err_q + 16'h0001;
		end
	end

	// pass pin low for a fixed time
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			pass_cnt_q <= 8'h00;
			pass_o <= 1'b1;
		end else if (done_q && ^frame_q && lk_q == audio_link_pkg::LK_LOCKED) begin
			pass_cnt_q <= 8'(`ALK_PASS_LOW_CYC - 1);
			pass_o <= 1'b0;
		end else if (pass_cnt_q != 8'h00) begin
			pass_cnt_q <= pass_cnt_q - 8'h01;
		end else begin
			pass_o <= 1'b1;
		end
	end

	// ----------------------------------------
	// Sample store
	// ----------------------------------------
	// TDM channels ascend from the start flag; stereo takes the channel from the lr bit
	always_comb begin
		if (fmt != audio_link_pkg::FMT_TDM) begin
			ch_nx = {2'h0, frame_q[`ALK_LR_BIT]};
		end else if (frame_q[`ALK_START_BIT]) begin
			ch_nx = 3'h0;
		end else begin
			ch_nx = (ch_q == 3'h7) ? 3'h7 : ch_q + 3'h1;
		end
	end

	// Frames with bad parity are dropped, not played
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			ch_q <= 3'h0;
			ctl_q <= 1'b0;
		end else if (done_q && !(^frame_q) && lk_q == audio_link_pkg::LK_LOCKED) begin
			ch_q <= ch_nx;
			ctl_q <= frame_q[`ALK_CTL_BIT];
		end
	end

	always_ff @(posedge clk_i) begin
		if (done_q && !(^frame_q) && lk_q == audio_link_pkg::LK_LOCKED) begin
			mem_q[ch_nx] <= frame_q[23:0];
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			ctrl_q <= `ALK_DES_CTRL_RST;
		end else if (reg_we_i && reg_addr_i == `ALK_DES_CTRL) begin
			ctrl_q <= reg_wdata_i[4:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i || !reg_re_i) begin
			reg_rdata_o <= 8'h00;
		end else begin
			case (reg_addr_i)
				`ALK_DES_ERR_LO: reg_rdata_o <= err_q[7:0];
				`ALK_DES_ERR_HI: reg_rdata_o <= err_q[15:8];
				`ALK_DES_CTRL: reg_rdata_o <= {3'h0, ctrl_q};
				`ALK_DES_STAT: reg_rdata_o <= {6'h00, ctl_q, lock_o};
				default: reg_rdata_o <= 8'h00;
			endcase
		end
	end

	// ----------------------------------------
	// Audio output engine
	// ----------------------------------------
	// system clock is half of 100 MHz
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			sck_o <= 1'b0;
		end else begin
			sck_o <= ~sck_o;
		end
	end

	// fixed slot widths hold 24-bit words
	always_ff @(posedge clk_i) begin
		if (sys_rst_i || div_q == 3'(`ALK_BCK_HALF - 1)) begin
			div_q <= 3'h0;
		end else begin
			div_q <= div_q + 3'h1;
		end
	end

	assign fall = (div_q == 3'(`ALK_BCK_HALF - 1)) && bck_o;

	always_comb begin
		sh = 3'h5;
		last = 8'h3F;
		if (fmt == audio_link_pkg::FMT_TDM) begin
			last = 8'hFF;
			case (ctrl_q[3:2])
				2'h0: sh = 3'h7;
				2'h1: sh = 3'h6;
				default: sh = 3'h5;
			endcase
		end
		nc = (cnt_q == last) ? 8'h00 : cnt_q + 8'h01;
		slot = 3'(nc >> sh);
		pos = nc - 8'(8'(slot) << sh);
		word = (pos == 8'h00) ? mem_q[slot] : cur_q;
		off = (1 << sh) - `ALK_SMP_W;
		case (fmt)
			// MSB one bit after the word clock
			audio_link_pkg::FMT_STD: k = int'(pos) - 1;
			// LSB in the last bit of the slot
			audio_link_pkg::FMT_RJ: k = int'(pos) - off;
			default: k = int'(pos);
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			bck_o <= 1'b0;
			cnt_q <= 8'hFF;
			cur_q <= 24'h000000;
			lrck_o <= 1'b0;
			dout_o <= 1'b0;
		end else if (div_q == 3'(`ALK_BCK_HALF - 1)) begin
			bck_o <= ~bck_o;
			if (fall) begin
				cnt_q <= nc;
				cur_q <= word;
				dout_o <= (k >= 0 && k < `ALK_SMP_W) ? word[5'(`ALK_SMP_W - 1 - k)] : 1'b0;
				if (fmt == audio_link_pkg::FMT_TDM) begin
					// pulse one bit or one slot wide
					lrck_o <= ctrl_q[4] ? (slot == 3'h0) : (nc == 8'h00);
				end else begin
					lrck_o <= slot[0];
				end
			end
		end
	end

endmodule

//--- dv/audio_link_assertions.sv
`timescale 1ns/1ps

module audio_link_checker (
	// Clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// Link
	input wire logic link_clk,
	input wire logic link_data,
	input wire logic link_sync,
	// Device outputs
	input wire logic sck_o,
	input wire logic bck_o,
	input wire logic lrck_o,
	input wire logic dout_o,
	input wire logic lock_o,
	input wire logic pass_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	// ----------
	// Helpers
	// ----------
	logic link_clk_q;
	logic link_rise;
	logic [7:0] idle_q;
	logic [5:0] bits_q;
	logic [7:0] low_q;

	assign link_rise = link_clk && !link_clk_q;

	always_ff @(posedge clk_i) begin
		link_clk_q <= link_clk;
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i || link_rise)
			idle_q <= 8'h00;
		else if (idle_q != 8'hFF)
			idle_q <= idle_q + 8'h01;
	end

	// Zero means frame position unknown, so a restart after idle is not judged
	always_ff @(posedge clk_i) begin
		if (sys_rst_i)
			bits_q <= 6'h00;
		else if (link_rise)
			bits_q <= link_sync ? 6'h01 :
				(bits_q == 6'h00 || bits_q == 6'h3F) ? bits_q : bits_q + 6'h01;
		else if (idle_q >= 8'h40)
			bits_q <= 6'h00;
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i || pass_o)
			low_q <= 8'h00;
		else if (low_q != 8'hFF)
			low_q <= low_q + 8'h01;
	end

	// ----------
	// Properties
	// ----------
	AST_LINK_CHANGE: assert property (($changed(link_data) || $changed(link_sync)) |-> !link_clk)
		else $error("link data moved while link clock high");
	AST_FRAME_BITS: assert property ((link_rise && link_sync && bits_q != 6'h00) |-> bits_q == 6'h1C)
		else $error("frame length differs from 28 bits");
	AST_FRAME_LONG: assert property ((link_rise && !link_sync) |-> bits_q < 6'h1C)
		else $error("frame marker missing after 28 bits");
	AST_BCK_HIGH: assert property (($rose(bck_o) && lock_o) |-> bck_o[*4] ##1 !bck_o)
		else $error("bit clock high phase not 4 cycles");
	AST_OUT_EDGE: assert property (($changed(dout_o) || $changed(lrck_o)) |-> !bck_o)
		else $error("audio output moved with bit clock high");
	AST_SCK_TOGGLE: assert property (!$past(sys_rst_i) |-> sck_o != $past(sck_o))
		else $error("system clock output not toggling each cycle");
	AST_PASS_WIDTH: assert property ($rose(pass_o) |-> low_q == 8'h64)
		else $error("pass pulse not 100 cycles");
	AST_PASS_LOCKED: assert property ($fell(pass_o) |-> lock_o)
		else $error("error flagged while unlocked");
	AST_LOCK_LOST: assert property ((idle_q == 8'h5A) |-> !lock_o)
		else $error("lock held with link clock stopped");
	AST_LOCK_GAIN: assert property ($rose(lock_o) |-> idle_q < 8'h14)
		else $error("lock gained without link traffic");

	cover property ($rose(lock_o));
	cover property ($fell(lock_o));
	cover property ($fell(pass_o));
endmodule

//--- dv/test_audio_link_deserializer_output.sv
`timescale 1ns/1ps
`include "audio_link_cfg.svh"

`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin fails++; \
	$display("ERROR %s expected %h seen %h", nm, e, g); end end

module test_audio_link_deserializer_output;
	logic clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic [1:0] we = 2'h0;
	logic [1:0] re = 2'h0;
	logic [7:0] des_rdata;
	logic [7:0] ser_rdata;
	logic smp_valid = 1'b0;
	logic smp_ready;
	logic [2:0] ch_q = 3'h0;
	logic [2:0] ch_mask = 3'h1;
	logic [23:0] smp_data;
	logic sck, bck, lrck, dout, lock, pass;
	int total_checks = 0;
	int fails = 0;

	function automatic logic [23:0] word_for(input logic [2:0] c);
		return {c, 5'h1B, 8'h81 ^ {5'h00, c}, 8'hE7};
	endfunction

	always #5 clk_i = ~clk_i;

	// Channel index walks the slots; start marks channel 0
	always @(posedge clk_i) begin
		if (smp_valid && smp_ready)
			ch_q <= (ch_q + 3'h1) & ch_mask;
	end
	assign smp_data = word_for(ch_q);

	audio_link_if link_bus();

	audio_link_ser u_audio_link_ser (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(addr),
		.reg_wdata_i(wdata), .reg_we_i(we[1]), .reg_re_i(re[1]), .reg_rdata_o(ser_rdata),
		.smp_data_i(smp_data), .smp_start_i(ch_q == 3'h0), .smp_lr_i(ch_q[0]),
		.smp_valid_i(smp_valid), .smp_ready_o(smp_ready), .link(link_bus));

	audio_link_des u_audio_link_des (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .link(link_bus),
		.reg_addr_i(addr), .reg_wdata_i(wdata), .reg_we_i(we[0]), .reg_re_i(re[0]),
		.reg_rdata_o(des_rdata), .sck_o(sck), .bck_o(bck), .lrck_o(lrck), .dout_o(dout),
		.lock_o(lock), .pass_o(pass));

	audio_link_checker chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
		.link_clk(link_bus.link_clk), .link_data(link_bus.link_data),
		.link_sync(link_bus.link_sync), .sck_o(sck), .bck_o(bck), .lrck_o(lrck), .dout_o(dout),
		.lock_o(lock), .pass_o(pass));

	// ----------
	// Bus and wait tasks
	// ----------
	task automatic wr(input logic s, input logic [7:0] a, input logic [7:0] v);
		@(posedge clk_i);
		addr <= a;
		wdata <= v;
		we <= s ? 2'h2 : 2'h1;
		@(posedge clk_i);
		we <= 2'h0;
	endtask

	task automatic rd(input logic s, input logic [7:0] a, input logic [7:0] e, input string nm);
		@(posedge clk_i);
		addr <= a;
		re <= s ? 2'h2 : 2'h1;
		@(posedge clk_i);
		re <= 2'h0;
		#1;
		`CHK(nm, e, s ? ser_rdata : des_rdata)
	endtask

	task automatic wait_pin(input logic use_pass, input logic lvl, input int lim);
		int n;
		n = 0;
		while ((use_pass ? pass : lock) !== lvl && n < lim) begin
			@(negedge clk_i);
			n++;
		end
	endtask

	task automatic find_edge(input logic pol);
		logic prev;
		prev = pol;
		for (int n = 0; n < 600; n++) begin
			@(posedge bck);
			if (lrck === pol && prev !== pol)
				break;
			prev = lrck;
		end
	endtask

	task automatic get_word(input logic pol, input int skip, input logic [23:0] e, input string nm);
		logic [23:0] w;
		find_edge(pol);
		repeat (skip) @(posedge bck);
		for (int n = 23; n >= 0; n--) begin
			w[n] = dout;
			if (n > 0)
				@(posedge bck);
		end
		`CHK(nm, e, w)
	endtask

	// ----------
	// Scenarios
	// ----------
	task automatic reset_vals();
		`CHK("pass idle", 1'b1, pass);
		`CHK("lock idle", 1'b0, lock);
		rd(1'b0, `ALK_DES_CTRL, {3'h0, `ALK_DES_CTRL_RST}, "ctrl reset");
		rd(1'b0, `ALK_DES_ERR_HI, 8'h00, "err hi reset");
		rd(1'b1, `ALK_SER_CTRL, {5'h00, `ALK_SER_CTRL_RST}, "ser ctrl reset");
		wr(1'b0, `ALK_DES_ERR_LO, 8'h5A);
		rd(1'b0, `ALK_DES_ERR_LO, 8'h00, "err lo read only");
		wr(1'b0, 8'h7E, 8'hFF);
		rd(1'b0, 8'h7E, 8'h00, "unmapped");
	endtask

	task automatic link_up(input logic [7:0] ctl);
		wr(1'b1, `ALK_SER_CTRL, ctl);
		wait_pin(1'b0, 1'b1, 3000);
		`CHK("lock", 1'b1, lock);
	endtask

	task automatic stereo(input audio_link_pkg::fmt_t fmt, input int skip);
		wr(1'b0, `ALK_DES_CTRL, {6'h00, fmt});
		ch_mask <= 3'h1;
		repeat (4) find_edge(1'b1);
		get_word(1'b0, skip, word_for(3'h0), "left word");
		get_word(1'b1, skip, word_for(3'h1), "right word");
	endtask

	task automatic tdm(input logic [1:0] code, input int nch, input logic wide);
		int w;
		int slot;
		slot = 256 / nch;
		wr(1'b0, `ALK_DES_CTRL, {3'h0, wide, code, audio_link_pkg::FMT_TDM});
		ch_mask <= 3'(nch - 1);
		repeat (4) find_edge(1'b1);
		w = 1;
		while (w < 300) begin
			@(posedge bck);
			if (lrck !== 1'b1)
				break;
			w++;
		end
		`CHK("tdm pulse", wide ? slot : 1, w)
		get_word(1'b1, 0, word_for(3'h0), "first slot");
		get_word(1'b1, (nch - 1) * slot, word_for(3'(nch - 1)), "last slot");
	endtask

	task automatic parity_err(input logic [7:0] cnt);
		wr(1'b1, `ALK_SER_CTRL, 8'h03);
		wait_pin(1'b1, 1'b0, 600);
		`CHK("pass low", 1'b0, pass);
		wait_pin(1'b1, 1'b1, 300);
		`CHK("lock held", 1'b1, lock);
		rd(1'b1, `ALK_SER_CTRL, 8'h01, "force cleared");
		rd(1'b0, `ALK_DES_ERR_LO, cnt, "errors low");
		rd(1'b0, `ALK_DES_ERR_HI, 8'h00, "errors high");
	endtask

	task automatic lose_lock();
		wr(1'b1, `ALK_SER_CTRL, 8'h00);
		wait_pin(1'b0, 1'b0, 200);
		`CHK("lock lost", 1'b0, lock);
		rd(1'b0, `ALK_DES_ERR_LO, 8'h00, "errors cleared");
		link_up(8'h01);
		rd(1'b0, `ALK_DES_ERR_LO, 8'h00, "errors after relock");
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		repeat (4) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		smp_valid <= 1'b1;
		reset_vals();
		link_up(8'h05);
		repeat (500) @(posedge clk_i);
		rd(1'b0, `ALK_DES_STAT, 8'h03, "status ctl bit");
		stereo(audio_link_pkg::FMT_STD, 1);
		stereo(audio_link_pkg::FMT_LJ, 0);
		stereo(audio_link_pkg::FMT_RJ, 8);
		tdm(2'h2, 8, 1'b0);
		tdm(2'h1, 4, 1'b1);
		tdm(2'h0, 2, 1'b1);
		parity_err(8'h01);
		parity_err(8'h02);
		lose_lock();
		end_of_test();
	end

	initial begin
		repeat (95000) @(posedge clk_i);
		fails++;
		$display("ERROR watchdog expired");
		end_of_test();
	end
endmodule
